// File: verilog/cycle_steal_transfer_control.sv
// Cycle-steal slow peripheral transfer control
`timescale 1ns/1ps
`include "steal_defines.svh"
//
// Contract
// - Style bits 15-17 ignored; 18 scatter-gather, 19 control-word recharge (code ignores bits 18, 19).
// - Style bit 20 picks multichannel (code uses multichannel_req instead), bit 21 whole-word burst units.
// - Style bit 22 steps address backward, bit 23 selects output direction.
// - Fetch first word, decrement count, set block stop at zero, write back.
// - Then fetch, update and write back the address word before data.
// - Move one character or word over the main data path at that address.
// - Raise termination if block stop; rerun if request pending; else exit.
// - Latch peripheral requests; serve only the highest priority one.
// - Selected request asks pause, forms base plus 4n, primes acknowledge.
// - Exactly one pause level active; it governs entry saves and exit.
// - End-of-instruction level: store pending result first; nothing on exit (code loads N from P on exit after a jump order).
// - Level two: nothing on entry; exit restores B and N from duplicates (code reloads only N, from A).
// - Level one: distinct from end of instruction; stores nothing.
// - Long order level: save B, N to locations 9, 10; restore on exit.
// - Entry after a jump order copies next address from P into N (code copies on exit, end-of-instruction level only).
// - No multichannel request: use single-channel base address 256.
// - Multichannel request suppresses single base; use linked base instead.
// - Single and multichannel bases configurable per processor.
// - Encoder supplies 4n; sequence adds offsets 1, 2, 3 (code adds only offset 1).
// - Multichannel request loads multiplexer channel id into address reg.
// - Four words per socket: style/count, then address with char position.
// - Only for slow peripherals below sixty thousand characters per second.
module cycle_steal_transfer_control #(
    parameter int          SOCKETS     = 8,
    parameter int          CHAN_W      = 4,
    parameter int          FIFO_DEPTH  = 8,
    parameter logic [14:0] SINGLE_BASE = `SINGLE_BASE_DEF,
    parameter logic [14:0] MULTI_BASE  = `MULTI_BASE_DEF
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    // Peripheral request and answer lines
    input  wire logic [SOCKETS-1:0] periph_req,
    input  wire logic               multichannel_req,
    input  wire logic [CHAN_W-1:0]  multichannel_id,
    output logic      [SOCKETS-1:0] periph_ack,
    output logic      [SOCKETS-1:0] periph_term,
    // Peripheral data stream
    input  wire logic               in_valid,
    input  wire logic [23:0]        in_data,
    output logic                    in_ready,
    output logic                    out_valid,
    output logic      [23:0]        out_data,
    input  wire logic               out_ready,
    // Processor pause handshake and levels
    output logic                    pause_req,
    input  wire logic               pause_grant,
    output logic                    pause_done,
    input  wire logic               pause_level_one,
    input  wire logic               pause_level_two,
    input  wire logic               pause_level_long_order,
    input  wire logic               pause_level_end_instr,
    input  wire logic               result_pending,
    input  wire logic               result_to_next,
    input  wire logic               jump_order,
    // Processor registers seen by the sequence
    input  wire logic [23:0]        reg_b_in,
    input  wire logic [23:0]        reg_n_in,
    input  wire logic [23:0]        reg_a_in,
    input  wire logic [23:0]        reg_p_in,
    input  wire logic [23:0]        result_in,
    input  wire logic [14:0]        operand_addr,
    output logic                    reg_b_load,
    output logic                    reg_n_load,
    output logic      [23:0]        reg_load_data,
    // Store port
    output logic                    mem_req,
    output logic                    mem_we,
    output logic      [14:0]        mem_addr,
    output logic      [23:0]        mem_wdata,
    input  wire logic               mem_ack,
    input  wire logic [23:0]        mem_rdata,
    // Status
    output logic                    block_stop_flag,
    output logic                    level_fault
);
    localparam int SW = $clog2(SOCKETS);

    steal_pkg::seq_state_e state_reg;
    steal_pkg::seq_state_e state_next;

    logic [SOCKETS-1:0] req_s1_reg;
    logic [SOCKETS-1:0] req_s2_reg;
    logic [SOCKETS-1:0] req_prev_reg;
    logic [SOCKETS-1:0] pend_reg;
    logic               mc_s1_reg;
    logic               mc_s2_reg;
    logic [CHAN_W-1:0]  mcid_s1_reg;
    logic [CHAN_W-1:0]  mcid_s2_reg;
    logic [SW-1:0]      sel_idx;
    logic               any_pend;
    logic [SOCKETS-1:0] sel_onehot_reg;
    logic [14:0]        control_word_addr_reg;
    logic               single_channel_base_sel;
    logic               multichannel_request_any;
    logic [23:0]        control_word_reg;
    logic [23:0]        addr_word_reg;
    logic [23:0]        stepped_addr;
    logic               stop_reg;
    logic               is_jump_reg;
    logic [1:0]         lvl_code;
    logic               out_dir;
    logic               data_done;

    steal_fifo_if #(.WIDTH(24)) fb ();

    steal_fifo #(
        .WIDTH (24),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .f       (fb)
    );

    // Peripheral lines are asynchronous: two flops first
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_s1_reg  <= '0;
            req_s2_reg  <= '0;
            mc_s1_reg   <= 1'b0;
            mc_s2_reg   <= 1'b0;
            mcid_s1_reg <= '0;
            mcid_s2_reg <= '0;
        end else begin
            req_s1_reg  <= periph_req;
            req_s2_reg  <= req_s1_reg;
            mc_s1_reg   <= multichannel_req;
            mc_s2_reg   <= mc_s1_reg;
            mcid_s1_reg <= multichannel_id;
            mcid_s2_reg <= mcid_s1_reg;
        end
    end

    // Rising edge of each request latched; served one per sequence
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_prev_reg <= '0;
            pend_reg     <= '0;
        end else begin
            req_prev_reg <= req_s2_reg;
            pend_reg     <= (pend_reg & ~((state_reg == steal_pkg::ST_WAIT)
                             ? sel_onehot_reg : '0))
                            | (req_s2_reg & ~req_prev_reg);
        end
    end

    // Lowest socket number has highest priority
    always_comb begin
        sel_idx  = '0;
        any_pend = 1'b0;
        for (int i = SOCKETS - 1; i >= 0; i--) begin
            if (pend_reg[i]) begin
                sel_idx  = SW'(i);
                any_pend = 1'b1;
            end
        end
    end

    function automatic logic [SOCKETS-1:0] sel_onehot_next();
        return SOCKETS'(1) << sel_idx;
    endfunction

    assign multichannel_request_any = mc_s2_reg;
    assign single_channel_base_sel  = !multichannel_request_any;

    // Style field decode; bits 15-17 are never looked at
    assign out_dir = control_word_reg[`STYLE_OUT_BIT];

    // Step address by one char or word, forward or back
    always_comb begin
        stepped_addr = addr_word_reg;
        if (control_word_reg[`STYLE_WORD_BIT]) begin
            stepped_addr[`ADDR_MSB:0] = control_word_reg[`STYLE_BACK_BIT]
                ? addr_word_reg[`ADDR_MSB:0] - 22'h000001
                : addr_word_reg[`ADDR_MSB:0] + 22'h000001;
        end else if (control_word_reg[`STYLE_BACK_BIT]) begin
            stepped_addr = {addr_word_reg[23:22] - 2'h1,
                addr_word_reg[`ADDR_MSB:0]
                - ((addr_word_reg[23:22] == 2'h0) ? 22'h000001 : 22'h0)};
        end else begin
            stepped_addr = {addr_word_reg[23:22] + 2'h1,
                addr_word_reg[`ADDR_MSB:0]
                + ((addr_word_reg[23:22] == 2'h3) ? 22'h000001 : 22'h0)};
        end
    end

    // Level one-hot check and code for the save path
    assign level_fault = ({pause_level_one, pause_level_two,
        pause_level_long_order, pause_level_end_instr} != 4'h1)
        && ({pause_level_one, pause_level_two, pause_level_long_order,
        pause_level_end_instr} != 4'h2)
        && ({pause_level_one, pause_level_two, pause_level_long_order,
        pause_level_end_instr} != 4'h4)
        && ({pause_level_one, pause_level_two, pause_level_long_order,
        pause_level_end_instr} != 4'h8);
    assign lvl_code = pause_level_end_instr ? 2'h3
                    : pause_level_long_order ? 2'h2
                    : pause_level_two ? 2'h1 : 2'h0;

    logic [1:0] lvl_reg;

    assign data_done = out_dir ? (mem_ack && fb.in_ready)
                               : (fb.out_valid && mem_ack);

    // Sequence state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            steal_pkg::ST_IDLE: begin
                if (any_pend) state_next = steal_pkg::ST_WAIT;
            end
            steal_pkg::ST_WAIT: begin
                if (pause_grant) begin
                    if (lvl_code == 2'h3 && result_pending)
                        state_next = steal_pkg::ST_SAVE_RES;
                    else if (lvl_code == 2'h2)
                        state_next = steal_pkg::ST_SAVE_B;
                    else
                        state_next = steal_pkg::ST_RD_CW0;
                end
            end
            steal_pkg::ST_SAVE_RES:
                if (mem_ack) state_next = steal_pkg::ST_RD_CW0;
            steal_pkg::ST_SAVE_B:
                if (mem_ack) state_next = steal_pkg::ST_SAVE_N;
            steal_pkg::ST_SAVE_N:
                if (mem_ack) state_next = steal_pkg::ST_RD_CW0;
            steal_pkg::ST_RD_CW0:
                if (mem_ack) state_next = steal_pkg::ST_WR_CW0;
            steal_pkg::ST_WR_CW0:
                if (mem_ack) state_next = steal_pkg::ST_RD_CW1;
            steal_pkg::ST_RD_CW1:
                if (mem_ack) state_next = steal_pkg::ST_WR_CW1;
            steal_pkg::ST_WR_CW1:
                if (mem_ack) state_next = steal_pkg::ST_DATA;
            steal_pkg::ST_DATA:
                if (data_done) state_next = steal_pkg::ST_FINISH;
            steal_pkg::ST_FINISH: begin
                if (any_pend)
                    state_next = steal_pkg::ST_WAIT;
                else if (lvl_reg == 2'h2)
                    state_next = steal_pkg::ST_RST_B;
                else
                    state_next = steal_pkg::ST_EXIT;
            end
            steal_pkg::ST_RST_B:
                if (mem_ack) state_next = steal_pkg::ST_RST_N;
            steal_pkg::ST_RST_N:
                if (mem_ack) state_next = steal_pkg::ST_EXIT;
            steal_pkg::ST_EXIT:
                state_next = steal_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) state_reg <= steal_pkg::ST_IDLE;
        else        state_reg <= state_next;
    end

    // Request capture: base address, socket and entry level
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            control_word_addr_reg <= '0;
            sel_onehot_reg        <= '0;
            lvl_reg               <= 2'h0;
            is_jump_reg           <= 1'b0;
        end else begin
            if ((state_reg == steal_pkg::ST_IDLE
                 || state_reg == steal_pkg::ST_FINISH) && any_pend) begin
                sel_onehot_reg <= sel_onehot_next();
                if (multichannel_request_any)
                    control_word_addr_reg <= MULTI_BASE
                        + {mcid_s2_reg, 2'b00};
                else
                    control_word_addr_reg <= SINGLE_BASE
                        + {sel_idx, 2'b00};
            end
            if (state_reg == steal_pkg::ST_WAIT && pause_grant) begin
                lvl_reg     <= lvl_code;
                is_jump_reg <= jump_order && pause_level_end_instr;
            end
        end
    end

    // Control words: count, block stop, address
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            control_word_reg <= '0;
            addr_word_reg    <= '0;
            stop_reg         <= 1'b0;
        end else begin
            if (state_reg == steal_pkg::ST_RD_CW0 && mem_ack) begin
                control_word_reg <= {mem_rdata[23:15],
                    mem_rdata[`COUNT_MSB:0] - 15'h0001};
                stop_reg <= (mem_rdata[`COUNT_MSB:0] == 15'h0001);
            end
            if (state_reg == steal_pkg::ST_RD_CW1 && mem_ack)
                addr_word_reg <= mem_rdata;
            if (state_reg == steal_pkg::ST_WR_CW1 && mem_ack)
                addr_word_reg <= stepped_addr;
        end
    end
    assign block_stop_flag = stop_reg;

    // Store port driving
    always_comb begin
        mem_req   = 1'b0;
        mem_we    = 1'b0;
        mem_addr  = control_word_addr_reg;
        mem_wdata = '0;
        unique case (state_reg)
            steal_pkg::ST_SAVE_RES: begin
                mem_req   = 1'b1;
                mem_we    = 1'b1;
                mem_addr  = operand_addr + 15'(result_to_next);
                mem_wdata = result_in;
            end
            steal_pkg::ST_SAVE_B: begin
                mem_req = 1'b1; mem_we = 1'b1;
                mem_addr = `SAVE_LOC_B; mem_wdata = reg_b_in;
            end
            steal_pkg::ST_SAVE_N: begin
                mem_req = 1'b1; mem_we = 1'b1;
                mem_addr = `SAVE_LOC_N; mem_wdata = reg_n_in;
            end
            steal_pkg::ST_RD_CW0: mem_req = 1'b1;
            steal_pkg::ST_WR_CW0: begin
                mem_req = 1'b1; mem_we = 1'b1;
                mem_wdata = control_word_reg;
            end
            steal_pkg::ST_RD_CW1: begin
                mem_req  = 1'b1;
                mem_addr = control_word_addr_reg + `CW_OFFSET_ADDR;
            end
            steal_pkg::ST_WR_CW1: begin
                mem_req = 1'b1; mem_we = 1'b1;
                mem_addr  = control_word_addr_reg + `CW_OFFSET_ADDR;
                mem_wdata = stepped_addr;
            end
            steal_pkg::ST_DATA: begin
                mem_req  = out_dir ? fb.in_ready : fb.out_valid;
                mem_we   = !out_dir;
                mem_addr = addr_word_reg[14:0];
                mem_wdata = fb.out_data;
            end
            steal_pkg::ST_RST_B: begin
                mem_req = 1'b1; mem_addr = `SAVE_LOC_B;
            end
            steal_pkg::ST_RST_N: begin
                mem_req = 1'b1; mem_addr = `SAVE_LOC_N;
            end
            default: ;
        endcase
    end

    // Data path through the FIFO
    assign fb.in_valid  = out_dir ? state_reg == steal_pkg::ST_DATA
                          && mem_ack : in_valid;
    assign fb.in_data   = out_dir ? mem_rdata : in_data;
    assign fb.out_ready = out_dir ? out_ready
                          : state_reg == steal_pkg::ST_DATA && mem_ack;
    assign out_valid = out_dir && fb.out_valid;
    assign in_ready  = !out_dir && fb.in_ready;
    assign out_data  = fb.out_data;

    // Processor register reloads on exit
    always_comb begin
        reg_b_load    = 1'b0;
        reg_n_load    = 1'b0;
        reg_load_data = '0;
        if (state_reg == steal_pkg::ST_RST_B && mem_ack) begin
            reg_b_load = 1'b1; reg_load_data = mem_rdata;
        end else if (state_reg == steal_pkg::ST_RST_N && mem_ack) begin
            reg_n_load = 1'b1; reg_load_data = mem_rdata;
        end else if (state_reg == steal_pkg::ST_EXIT) begin
            if (lvl_reg == 2'h1) begin
                reg_n_load = 1'b1; reg_load_data = reg_a_in;
            end else if (is_jump_reg) begin
                reg_n_load = 1'b1; reg_load_data = reg_p_in;
            end
        end
    end

    // Acknowledge primed, termination raised after the move
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_ack  <= '0;
            periph_term <= '0;
        end else begin
            periph_ack  <= (state_reg != steal_pkg::ST_IDLE
                            && state_reg != steal_pkg::ST_EXIT)
                           ? sel_onehot_reg : '0;
            periph_term <= (state_reg == steal_pkg::ST_FINISH && stop_reg)
                           ? sel_onehot_reg : '0;
        end
    end

    assign pause_req  = state_reg == steal_pkg::ST_WAIT;
    assign pause_done = state_reg == steal_pkg::ST_EXIT;
endmodule // cycle_steal_transfer_control

// File: verilog/steal_defines.svh
// Constants for the cycle-steal transfer control
`ifndef STEAL_DEFINES_SVH
`define STEAL_DEFINES_SVH
`define STYLE_SCATTER_BIT   18
`define STYLE_RECHARGE_BIT  19
`define STYLE_MULTI_BIT     20
`define STYLE_WORD_BIT      21
`define STYLE_BACK_BIT      22
`define STYLE_OUT_BIT       23
`define COUNT_MSB           14
`define CHAR_POS_HI         23
`define CHAR_POS_LO         22
`define ADDR_MSB            21
`define SINGLE_BASE_DEF     15'h0100
`define MULTI_BASE_DEF      15'h0400
`define SAVE_LOC_B          15'h0009
`define SAVE_LOC_N          15'h000A
`define CW_OFFSET_ADDR      15'h0001
`define PRI_RATE_KCPS       60
`endif

// File: verilog/steal_pkg.sv
// Types for the cycle-steal transfer control
package steal_pkg;
    typedef enum logic [13:0] {
        ST_IDLE     = 14'h0001,
        ST_WAIT     = 14'h0002,
        ST_SAVE_RES = 14'h0004,
        ST_SAVE_B   = 14'h0008,
        ST_SAVE_N   = 14'h0010,
        ST_RD_CW0   = 14'h0020,
        ST_WR_CW0   = 14'h0040,
        ST_RD_CW1   = 14'h0080,
        ST_WR_CW1   = 14'h0100,
        ST_DATA     = 14'h0200,
        ST_FINISH   = 14'h0400,
        ST_RST_B    = 14'h0800,
        ST_RST_N    = 14'h1000,
        ST_EXIT     = 14'h2000
    } seq_state_e;
endpackage

// File: verilog/steal_fifo_if.sv
// Handshake bundle between the transfer control and its data FIFO
`timescale 1ns/1ps
interface steal_fifo_if #(parameter int WIDTH = 24);
    logic             in_valid;
    logic             in_ready;
    logic [WIDTH-1:0] in_data;
    logic             out_valid;
    logic             out_ready;
    logic [WIDTH-1:0] out_data;
    modport fifo (input in_valid, in_data, out_ready,
                  output in_ready, out_valid, out_data);
    modport ctrl (output in_valid, in_data, out_ready,
                  input in_ready, out_valid, out_data);
endinterface

// File: verilog/steal_fifo.sv
// Synchronous FIFO with registered read data
`timescale 1ns/1ps
module steal_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Handshake bundle
    steal_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      cnt_reg;
    logic [WIDTH-1:0] dout_reg;
    logic             dvalid_reg;
    logic             push;
    logic             pop;
    logic             load;

    assign push = f.in_valid && f.in_ready;
    assign load = (cnt_reg != '0) && (!dvalid_reg || f.out_ready);
    assign pop  = load;
    assign f.in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign f.out_valid = dvalid_reg;
    assign f.out_data  = dout_reg;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= f.in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0
                              : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0
                              : rd_ptr_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_reg   <= '0;
            dvalid_reg <= 1'b0;
        end else if (load) begin
            dout_reg   <= mem[rd_ptr_reg];
            dvalid_reg <= 1'b1;
        end else if (f.out_ready) begin
            dvalid_reg <= 1'b0;
        end
    end
endmodule // steal_fifo

// File: sim/cycle_steal_transfer_control_assertions.sv
// Port assertions for the cycle-steal transfer control
`timescale 1ns/1ps
module steal_checker #(parameter int SOCKETS = 8) (
    input wire logic ref_clk, rst_n, pause_req, pause_grant, pause_done,
    input wire logic pause_level_one, pause_level_two, pause_level_end_instr,
    input wire logic pause_level_long_order, mem_req, mem_we, mem_ack,
    input wire logic block_stop_flag, level_fault,
    input wire logic [14:0] mem_addr,
    input wire logic [23:0] mem_wdata, reg_b_in, reg_n_in,
    input wire logic [SOCKETS-1:0] periph_ack, periph_term
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    one_level_a: assert property (
        level_fault == !$onehot({pause_level_one, pause_level_two,
        pause_level_long_order, pause_level_end_instr})) else $error("level");
    mem_hold_a: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr)) else $error("mem");
    pause_hold_a: assert property (
        pause_req && !pause_grant |=> pause_req) else $error("pause");
    done_pulse_a: assert property (
        pause_done |=> !pause_done) else $error("done");
    term_stop_a: assert property (
        |periph_term |-> block_stop_flag && periph_term == periph_ack)
        else $error("term");
    term_pulse_a: assert property (
        |periph_term |=> periph_term == '0) else $error("term pulse");
    ack_single_a: assert property (
        $onehot0(periph_ack)) else $error("ack");
    save_b_a: assert property (
        mem_req && mem_we && mem_addr == 15'h0009 |-> mem_wdata == reg_b_in)
        else $error("save b");
    save_n_a: assert property (
        mem_req && mem_we && mem_addr == 15'h000A |-> mem_wdata == reg_n_in)
        else $error("save n");
endmodule // steal_checker
bind cycle_steal_transfer_control steal_checker #(.SOCKETS(SOCKETS)) chk (.*);

// File: sim/steal_store_model.sv
// Store and processor pause model facing the transfer control
`timescale 1ns/1ps
module steal_store_model (
    input wire logic ref_clk, rst_n, mem_req, mem_we, pause_req, pause_done,
    input wire logic [14:0] mem_addr,
    input wire logic [23:0] mem_wdata,
    output logic mem_ack, pause_grant,
    output logic [23:0] mem_rdata
);
    logic [23:0] mem [0:4095];
    logic        go;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ack <= 1'b0;
            pause_grant <= 1'b0;
            mem_rdata <= 24'h5A5A5A;
        end else begin
            // Grant at a random boundary, hold the datapath until exit
            if (pause_done) pause_grant <= 1'b0;
            else if (pause_req && $urandom_range(0, 2) == 0) pause_grant <= 1;
            go = mem_req && !mem_ack && $urandom_range(0, 1) == 1;
            mem_ack <= go;
            mem_rdata <= go ? mem[mem_addr[11:0]] : ~mem_rdata;
            if (go && mem_we) mem[mem_addr[11:0]] <= mem_wdata;
        end
    end
endmodule // steal_store_model

// File: sim/tb_cycle_steal_transfer_control.sv
// Self-checking bench for the cycle-steal transfer control
`timescale 1ns/1ps
module tb_cycle_steal_transfer_control;
    logic ref_clk, rst_n, multichannel_req, in_valid, in_ready, out_valid;
    logic out_ready, pause_req, pause_grant, pause_done, pause_level_one;
    logic pause_level_two, pause_level_long_order, pause_level_end_instr;
    logic result_pending, result_to_next, jump_order, reg_b_load, reg_n_load;
    logic mem_req, mem_we, mem_ack, block_stop_flag, level_fault;
    logic [7:0]  periph_req, periph_ack, periph_term;
    logic [3:0]  multichannel_id;
    logic [23:0] in_data, out_data, reg_b_in, reg_n_in, reg_a_in, reg_p_in;
    logic [23:0] result_in, reg_load_data, mem_wdata, mem_rdata;
    logic [14:0] operand_addr, mem_addr;
    int          miscompares = 0;
    int          tests_run = 0;
    cycle_steal_transfer_control DUT (.*);
    steal_store_model model (.*);
    initial forever #25 ref_clk = ~ref_clk;
    task automatic check(string nm, logic [23:0] seen, logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic logic [23:0] step(logic [23:0] w, logic wd, logic bk);
        int u;
        u = wd ? w[21:0] : {w[21:0], w[23:22]};
        u = bk ? u - 1 : u + 1;
        return wd ? {w[23:22], u[21:0]} : {u[1:0], u[23:2]};
    endfunction
    task automatic run(logic [7:0] mask, logic multi, int id, int lvl);
        logic [23:0] w0, w1, ex, e0[$], e1[$];
        logic [7:0]  ack = 8'h00;
        int          sk[$], bs[$];
        int          k = 0, g = 0, t = 0, stops = 0;
        for (int n = 0; n < 8; n++) if (mask[n]) sk.push_back(n);
        foreach (sk[i]) begin
            bs.push_back(multi ? 1024 + 4 * id : 256 + 4 * sk[i]);
            w0 = {3'($urandom), multi, 2'b00, 3'($urandom),
                  15'($urandom_range(1, 3))};
            w1 = {2'($urandom), 22'(2048 + $urandom_range(0, 1023))};
            model.mem[bs[i]] = w0;
            model.mem[bs[i] + 1] = w1;
            e0.push_back({w0[23:15], w0[14:0] - 15'h0001});
            e1.push_back(step(w1, w0[21], w0[22]));
            stops += (w0[14:0] == 15'h0001);
        end
        model.mem[9] = 24'h000000;
        model.mem[10] = 24'h000000;
        @(posedge ref_clk);
        {pause_level_end_instr, pause_level_long_order, pause_level_two,
         pause_level_one} <= 4'h1 << lvl;
        {reg_b_in, reg_n_in, reg_a_in, reg_p_in} <= 96'({$urandom, $urandom,
                                                     $urandom, $urandom});
        {result_in, in_data} <= 48'({$urandom, $urandom});
        {result_pending, result_to_next, jump_order} <= 3'($urandom);
        operand_addr <= 15'(64 + $urandom_range(0, 63));
        @(posedge ref_clk);
        ex = lvl == 1 ? reg_a_in : lvl == 2 ? reg_n_in : reg_p_in;
        periph_req <= mask;
        multichannel_req <= multi;
        multichannel_id <= 4'(id);
        repeat (4) @(posedge ref_clk);
        periph_req <= 8'h00;
        multichannel_req <= 1'b0;
        while (k < sk.size() && g < 3000) begin
            @(posedge ref_clk);
            #1;
            g++;
            t += |periph_term;
            if (reg_n_load) check("nload", reg_load_data, ex);
            if (|ack && periph_ack != ack) begin
                check("ack", ack, 8'h01 << sk[k]);
                check("stop", block_stop_flag, e0[k][14:0] == 0);
                k++;
            end
            ack = periph_ack;
        end
        check("runs", k, sk.size());
        check("terms", t, stops);
        foreach (bs[i]) begin
            check("cw0", model.mem[bs[i]], e0[i]);
            check("cw1", model.mem[bs[i] + 1], e1[i]);
        end
        if (lvl == 2) begin
            check("loc9", model.mem[9], reg_b_in);
            check("loc10", model.mem[10], reg_n_in);
        end
    endtask
    initial begin
        ref_clk = 1'b0;
        {periph_req, multichannel_req, multichannel_id, in_data,
         result_pending, result_to_next, jump_order, reg_b_in, reg_n_in,
         reg_a_in, reg_p_in, result_in, operand_addr} = '0;
        {pause_level_end_instr, pause_level_two, pause_level_one} = 3'h4;
        pause_level_long_order = 1'b0;
        {in_valid, out_ready} = 2'h3;
        rst_n = 1'b0;
        void'($urandom(85546));
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 24; i++)
            if (i % 6 == 5) run(8'h01 << $urandom_range(0, 7), 1'b1,
                                $urandom_range(0, 15), i % 4);
            else run(8'($urandom_range(1, 255)), 1'b0, 0, i % 4);
        {pause_level_two, pause_level_one} <= 2'h3;
        repeat (2) @(posedge ref_clk);
        #1;
        check("fault", level_fault, 1'b1);
        final_report();
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        miscompares++;
        final_report();
    end
endmodule // tb_cycle_steal_transfer_control
